// File: ucg_pkg.sv
// Operation
// - separate receive and transmit paths, full duplex
// - five to nine data bits, one/two stops
// - hardware parity generate and check
// - flag framing, overrun and parity errors
// - low-pass filter line, reject false starts
// - interrupts: transmit complete, buffer empty, receive complete
// - transmit buffer allows back-to-back frames
// - receiver recovers timing from asynchronous data
// - four clock modes supported
// - mode bit selects synchronous or asynchronous
// - speed bit enables double-speed asynchronous
// - clock pin direction picks master or slave
// - down counter reloads at zero, low write
// - one pulse per zero, rate over divider+1
// - bit rate divides by 16, 8, 2
// - divider is high and low registers joined
// - doubling only asynchronous, transmitter bit timing halved too
// - slave clock synchronised, two-cycle delay, below quarter
// - polarity picks change and sample edges
package ucg_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [4:0] A_DATA = 5'h00;
  localparam logic [4:0] A_CTRL = 5'h04;
  localparam logic [4:0] A_BLO = 5'h08;
  localparam logic [4:0] A_BHI = 5'h0C;
  localparam logic [4:0] A_STAT = 5'h10;
  localparam logic [4:0] A_MASK = 5'h14;

  // ==========================================================
  // control field positions
  localparam int C_RXEN = 0;
  localparam int C_TXEN = 1;
  localparam int C_SYNC = 2;
  localparam int C_DBL = 3;
  localparam int C_CPOL = 4;
  localparam int C_XOUT = 5;
  localparam int C_DB = 6;
  localparam int C_PEN = 10;
  localparam int C_PODD = 9;
  localparam int C_STOP2 = 11;
  localparam logic [11:0] CTRL_RST = 12'h0C0;

  // ==========================================================
  // status field positions
  localparam int S_TXC = 0;
  localparam int S_UDRE = 1;
  localparam int S_RXC = 2;
  localparam int S_FE = 3;
  localparam int S_DOR = 4;
  localparam int S_PE = 5;

  // ==========================================================
  // oversampling counts (last index, mid index), data bit limits
  localparam logic [3:0] OS_LAST_NORM = 4'hF;
  localparam logic [3:0] OS_LAST_DBL = 4'h7;
  localparam logic [3:0] OS_MID_NORM = 4'h7;
  localparam logic [3:0] OS_MID_DBL = 4'h3;
  localparam logic [3:0] DB_MIN = 4'h5;
  localparam logic [3:0] DB_MAX = 4'h9;

  // ==========================================================
  // frame phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_START = 3'h1,
    PH_DATA = 3'h2,
    PH_PAR = 3'h3,
    PH_STOP1 = 3'h4,
    PH_STOP2 = 3'h5
  } ucg_ph_e;

  // whole block state
  typedef struct packed {
    logic [11:0] ctrl;
    logic [7:0] div_lo;
    logic [3:0] div_hi;
    logic [11:0] bcnt;
    logic [5:0] stat;
    logic [5:0] mask;
    logic wr_pend;
    logic [4:0] wr_addr;
    logic [31:0] rdata;
    logic rxd_s1, rxd_s2, xck_s1, xck_s2, xck_d, xck_q;
    logic txd;
    ucg_ph_e tx_ph;
    logic [8:0] tbuf;
    logic tbuf_v;
    logic [8:0] tsh;
    logic [3:0] tbit;
    logic tpar;
    logic [3:0] tdiv;
    ucg_ph_e rx_ph;
    logic [2:0] filt;
    logic [3:0] rdiv;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic rpar;
    logic [8:0] rdat;
    logic rdat_v;
  } ucg_st_s;

  localparam ucg_st_s ST_RST = '{ctrl: CTRL_RST, txd: 1'b1, tx_ph: PH_IDLE, rx_ph: PH_IDLE,
    filt: 3'h7, rxd_s1: 1'b1, rxd_s2: 1'b1, default: '0};

endpackage

// File: ucg_top.sv
`timescale 1ns/1ps
module ucg_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial pins
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic xck_i,
  output logic xck_o,
  output logic xck_oe,
  // interrupt
  output logic irq
);

  // ==========================================================
  // helpers
  // majority of three filter taps
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // data bit count from the size field, clamped
  function automatic logic [3:0] nbits(input logic [2:0] c);
    logic [3:0] s;
    s = {1'b0, c} + ucg_pkg::DB_MIN;
    nbits = (s > ucg_pkg::DB_MAX) ? ucg_pkg::DB_MAX : s;
  endfunction

  // ==========================================================
  // state
  ucg_pkg::ucg_st_s st_r; // all flops
  ucg_pkg::ucg_st_s st_nxt; // next value
  logic sync; // synchronous mode
  logic master; // driving the clock pin
  logic dbl; // double speed in effect
  logic tick; // baud generator pulse
  logic lo_wr; // low divider write this cycle
  logic rise, fall; // serial clock edges
  logic drv, smp; // change and sample edges
  logic [3:0] os_last, os_mid; // oversample points
  logic [3:0] nb; // data bits per frame
  logic pen, podd; // parity enable, odd
  logic tadv; // transmitter bit boundary
  logic tload; // move buffer into shifter
  logic rs; // receiver sample point
  logic rbv; // receiver bit value
  logic aph; // valid address phase
  logic [5:0] set_v, clr_v; // status set and clear

  // ==========================================================
  // next-state logic
  always_comb begin
    st_nxt = st_r;
    set_v = '0;
    clr_v = '0;
    tload = 1'b0;
    // mode decode
    sync = st_r.ctrl[ucg_pkg::C_SYNC];
    master = sync & st_r.ctrl[ucg_pkg::C_XOUT];
    // doubling is ignored in synchronous mode
    dbl = st_r.ctrl[ucg_pkg::C_DBL] & ~sync;
    os_last = dbl ? ucg_pkg::OS_LAST_DBL : ucg_pkg::OS_LAST_NORM;
    os_mid = dbl ? ucg_pkg::OS_MID_DBL : ucg_pkg::OS_MID_NORM;
    nb = nbits(st_r.ctrl[ucg_pkg::C_DB +: 3]);
    pen = st_r.ctrl[ucg_pkg::C_PEN];
    podd = st_r.ctrl[ucg_pkg::C_PODD];
    lo_wr = st_r.wr_pend && (st_r.wr_addr == ucg_pkg::A_BLO);

    // pin synchronisers, second stage feeds all logic
    st_nxt.rxd_s1 = rxd_i;
    st_nxt.rxd_s2 = st_r.rxd_s1;
    st_nxt.xck_s1 = xck_i;
    st_nxt.xck_s2 = st_r.xck_s1;
    st_nxt.xck_d = st_r.xck_s2;

    // baud down counter on the system clock
    tick = (st_r.bcnt == 12'h000);
    if (tick) begin
      st_nxt.bcnt = {st_r.div_hi, st_r.div_lo};
    end else begin
      st_nxt.bcnt = st_r.bcnt - 12'h001;
    end

    // serial clock: toggle per pulse as master, else edges of the pin
    if (master) begin
      if (tick) begin
        st_nxt.xck_q = ~st_r.xck_q;
      end
      rise = tick & ~st_r.xck_q;
      fall = tick & st_r.xck_q;
    end else begin
      // two flops of delay before the edge is seen
      rise = st_r.xck_s2 & ~st_r.xck_d;
      fall = ~st_r.xck_s2 & st_r.xck_d;
    end
    // polarity one: change on falling, sample on rising
    drv = st_r.ctrl[ucg_pkg::C_CPOL] ? fall : rise;
    smp = st_r.ctrl[ucg_pkg::C_CPOL] ? rise : fall;

    // ==========================================================
    // bus address phase: reads answer from a flop next cycle
    aph = hsel && htrans[1] && hready && (hsize == 3'h2);
    st_nxt.wr_pend = aph && hwrite;
    st_nxt.wr_addr = haddr[4:0];
    if (aph && !hwrite) begin
      unique case (haddr[4:0])
        ucg_pkg::A_DATA: begin
          st_nxt.rdata = {23'h0, st_r.rdat};
          st_nxt.rdat_v = 1'b0; // reading pops the word
        end
        ucg_pkg::A_CTRL: st_nxt.rdata = {20'h0, st_r.ctrl};
        ucg_pkg::A_BLO: st_nxt.rdata = {24'h0, st_r.div_lo};
        ucg_pkg::A_BHI: st_nxt.rdata = {28'h0, st_r.div_hi};
        ucg_pkg::A_STAT: st_nxt.rdata = {24'h0, st_r.rdat_v, ~st_r.tbuf_v, st_r.stat};
        ucg_pkg::A_MASK: st_nxt.rdata = {26'h0, st_r.mask};
        default: st_nxt.rdata = 32'h0000_0000; // unmapped reads zero
      endcase
    end

    // bus data phase writes
    if (st_r.wr_pend) begin
      unique case (st_r.wr_addr)
        ucg_pkg::A_DATA: begin
          // a write into a full buffer is dropped
          if (!st_r.tbuf_v) begin
            st_nxt.tbuf = hwdata[8:0];
            st_nxt.tbuf_v = 1'b1;
          end
        end
        ucg_pkg::A_CTRL: st_nxt.ctrl = hwdata[11:0];
        ucg_pkg::A_BLO: begin
          st_nxt.div_lo = hwdata[7:0];
          st_nxt.bcnt = {st_r.div_hi, hwdata[7:0]};
        end
        ucg_pkg::A_BHI: st_nxt.div_hi = hwdata[3:0];
        ucg_pkg::A_STAT: clr_v = hwdata[5:0];
        ucg_pkg::A_MASK: st_nxt.mask = hwdata[5:0];
        default: ; // unmapped writes ignored
      endcase
    end

    // ==========================================================
    // transmitter, own shifter and timing
    if (!sync && tick) begin
      st_nxt.tdiv = (st_r.tdiv == os_last) ? 4'h0 : st_r.tdiv + 4'h1;
    end
    tadv = sync ? drv : (tick && (st_r.tdiv == os_last));
    unique case (st_r.tx_ph)
      ucg_pkg::PH_IDLE: begin
        tload = tadv && st_r.tbuf_v && st_r.ctrl[ucg_pkg::C_TXEN];
      end
      ucg_pkg::PH_START: begin
        if (tadv) begin
          st_nxt.txd = st_r.tsh[0];
          st_nxt.tbit = 4'h0;
          st_nxt.tx_ph = ucg_pkg::PH_DATA;
        end
      end
      ucg_pkg::PH_DATA: begin
        if (tadv) begin
          if (st_r.tbit == nb - 4'h1) begin
            // parity sits between last data bit and stop
            st_nxt.txd = pen ? st_r.tpar : 1'b1;
            st_nxt.tx_ph = pen ? ucg_pkg::PH_PAR : ucg_pkg::PH_STOP1;
          end else begin
            st_nxt.tsh = {1'b0, st_r.tsh[8:1]};
            st_nxt.txd = st_r.tsh[1];
            st_nxt.tbit = st_r.tbit + 4'h1;
          end
        end
      end
      ucg_pkg::PH_PAR: begin
        if (tadv) begin
          st_nxt.txd = 1'b1;
          st_nxt.tx_ph = ucg_pkg::PH_STOP1;
        end
      end
      ucg_pkg::PH_STOP1, ucg_pkg::PH_STOP2: begin
        if (tadv) begin
          if (st_r.tx_ph == ucg_pkg::PH_STOP1 && st_r.ctrl[ucg_pkg::C_STOP2]) begin
            st_nxt.tx_ph = ucg_pkg::PH_STOP2;
          end else if (st_r.tbuf_v && st_r.ctrl[ucg_pkg::C_TXEN]) begin
            tload = 1'b1; // next start follows the stop directly
          end else begin
            st_nxt.tx_ph = ucg_pkg::PH_IDLE;
            set_v[ucg_pkg::S_TXC] = 1'b1;
          end
        end
      end
      default: st_nxt.tx_ph = ucg_pkg::PH_IDLE; // illegal code recovery
    endcase
    if (tload) begin
      st_nxt.tsh = st_r.tbuf;
      st_nxt.tpar = ^(st_r.tbuf & (9'h1FF >> (4'd9 - nb))) ^ podd;
      st_nxt.tbuf_v = 1'b0;
      st_nxt.txd = 1'b0;
      st_nxt.tx_ph = ucg_pkg::PH_START;
      set_v[ucg_pkg::S_UDRE] = 1'b1;
    end

    // ==========================================================
    // receiver: filter, start check, mid-bit sampling
    if (!sync && tick) begin
      st_nxt.filt = {st_r.filt[1:0], st_r.rxd_s2};
      st_nxt.rdiv = st_r.rdiv + 4'h1;
    end
    rbv = sync ? st_r.rxd_s2 : maj3(st_r.filt);
    // sample point counted from the start edge, which resyncs timing
    rs = sync ? smp : (tick && (st_r.rdiv ==
      ((st_r.rx_ph == ucg_pkg::PH_START) ? os_mid : os_last)));
    if (!sync && rs) begin
      st_nxt.rdiv = 4'h0;
    end
    unique case (st_r.rx_ph)
      ucg_pkg::PH_IDLE: begin
        if (sync) begin
          if (smp && !rbv) begin
            st_nxt.rx_ph = ucg_pkg::PH_DATA;
            st_nxt.rbit = 4'h0;
            st_nxt.rpar = 1'b0;
          end
        end else if (tick && !rbv) begin
          st_nxt.rx_ph = ucg_pkg::PH_START;
          st_nxt.rdiv = 4'h0;
        end
      end
      ucg_pkg::PH_START: begin
        if (rs) begin
          if (rbv) begin
            st_nxt.rx_ph = ucg_pkg::PH_IDLE; // false start
          end else begin
            st_nxt.rx_ph = ucg_pkg::PH_DATA;
            st_nxt.rbit = 4'h0;
            st_nxt.rpar = 1'b0;
          end
        end
      end
      ucg_pkg::PH_DATA: begin
        if (rs) begin
          st_nxt.rsh = {rbv, st_r.rsh[8:1]};
          st_nxt.rpar = st_r.rpar ^ rbv;
          if (st_r.rbit == nb - 4'h1) begin
            st_nxt.rx_ph = pen ? ucg_pkg::PH_PAR : ucg_pkg::PH_STOP1;
          end else begin
            st_nxt.rbit = st_r.rbit + 4'h1;
          end
        end
      end
      ucg_pkg::PH_PAR: begin
        if (rs) begin
          // rpar now holds one on mismatch
          st_nxt.rpar = st_r.rpar ^ rbv ^ podd;
          st_nxt.rx_ph = ucg_pkg::PH_STOP1;
        end
      end
      ucg_pkg::PH_STOP1: begin
        if (rs) begin
          // only the first stop bit is checked
          st_nxt.rx_ph = ucg_pkg::PH_IDLE;
          set_v[ucg_pkg::S_FE] = ~rbv;
          if (st_nxt.rdat_v) begin
            set_v[ucg_pkg::S_DOR] = 1'b1; // unread word kept
          end else begin
            st_nxt.rdat = st_r.rsh >> (4'd9 - nb);
            st_nxt.rdat_v = 1'b1;
            set_v[ucg_pkg::S_RXC] = 1'b1;
            set_v[ucg_pkg::S_PE] = pen & st_r.rpar;
          end
        end
      end
      default: st_nxt.rx_ph = ucg_pkg::PH_IDLE; // illegal code recovery
    endcase
    if (!st_r.ctrl[ucg_pkg::C_RXEN]) begin
      st_nxt.rx_ph = ucg_pkg::PH_IDLE;
    end

    // sticky status, set wins over clear
    st_nxt.stat = (st_r.stat & ~clr_v) | set_v;
  end

  // ==========================================================
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ucg_pkg::ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always okay
  assign hrdata = st_r.rdata;
  assign txd_o = st_r.txd;
  assign xck_o = st_r.xck_q;
  assign xck_oe = st_r.ctrl[ucg_pkg::C_SYNC] & st_r.ctrl[ucg_pkg::C_XOUT];
  assign irq = |(st_r.stat & st_r.mask);

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_reload;
    (st_r.bcnt == 12'h000 && !lo_wr) |=> st_r.bcnt == $past({st_r.div_hi, st_r.div_lo});
  endproperty
  a_reload: assert property (p_reload) else $error("counter missed reload at zero");

  property p_lo_wr;
    lo_wr |=> st_r.bcnt == {st_r.div_hi, st_r.div_lo};
  endproperty
  a_lo_wr: assert property (p_lo_wr) else $error("low divider write did not reload");

  property p_count;
    (st_r.bcnt != 12'h000 && !lo_wr) |=> st_r.bcnt == $past(st_r.bcnt) - 12'h001;
  endproperty
  a_count: assert property (p_count) else $error("counter did not step down");

  property p_master_clk;
    (master && tick) |=> xck_o != $past(xck_o);
  endproperty
  a_master_clk: assert property (p_master_clk) else $error("master clock did not toggle");

  property p_oe;
    !st_r.ctrl[ucg_pkg::C_SYNC] |-> !xck_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("clock pin driven in async mode");

  property p_start_low;
    (st_r.tx_ph == ucg_pkg::PH_START) |-> !txd_o;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_stop_high;
    (st_r.tx_ph == ucg_pkg::PH_STOP1 || st_r.tx_ph == ucg_pkg::PH_STOP2) |-> txd_o;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

  property p_false_start;
    (st_r.rx_ph == ucg_pkg::PH_START && rs && rbv) |=> st_r.rx_ph == ucg_pkg::PH_IDLE;
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start accepted");

  property p_txc;
    (st_r.tx_ph == ucg_pkg::PH_STOP1 && tadv && !st_r.ctrl[ucg_pkg::C_STOP2] &&
      !st_r.tbuf_v) |=> st_r.stat[ucg_pkg::S_TXC] && st_r.tx_ph == ucg_pkg::PH_IDLE;
  endproperty
  a_txc: assert property (p_txc) else $error("transmit complete not flagged");

  property p_set_wins;
    (|set_v) |=> (st_r.stat & $past(set_v)) == $past(set_v);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status event lost to clear");

  property p_load;
    tload |=> st_r.stat[ucg_pkg::S_UDRE] && st_r.tx_ph == ucg_pkg::PH_START && !txd_o;
  endproperty
  a_load: assert property (p_load) else $error("buffer not moved into shifter");

endmodule

// File: ucg_remote.sv
`timescale 1ns/1ps
// ====================================
// remote serial transceiver model
module ucg_remote (
  // time base
  input wire logic clk,
  // serial lines
  input wire logic txd,
  output logic rxd,
  output logic xck
);
  int bit_clks = 32; // clocks per bit
  int rx_bits = 9; // bits after start
  logic sync_mode = 1'b0; // drive xck too
  logic [10:0] got_q[$]; // frames, lsb first
  int start_t[$]; // start edge times in ns, exact at the launching edge

  // capture: mid bit sampling, lsb first
  always begin : rx_side
    logic [10:0] w;
    w = '0;
    @(negedge txd);
    start_t.push_back(int'($time));
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < rx_bits; i++) begin
      repeat (bit_clks) @(posedge clk);
      w[i] = txd;
    end
    got_q.push_back(w);
  end

  // change on falling xck, idle high
  // half bit of 4+ clocks keeps xck under a quarter
  task automatic put_bit(input logic b);
    rxd <= b;
    xck <= ~sync_mode;
    repeat (bit_clks / 2) @(posedge clk);
    xck <= 1'b1;
    repeat (bit_clks / 2) @(posedge clk);
  endtask

  // start, then n bits, then idle high
  task automatic send(input logic [10:0] w, input int n);
    put_bit(1'b0);
    for (int i = 0; i < n; i++) begin
      put_bit(w[i]);
    end
    rxd <= 1'b1;
  endtask

  // low pulse far shorter than half a bit
  task automatic glitch();
    rxd <= 1'b0;
    repeat (4) @(posedge clk);
    rxd <= 1'b1;
  endtask

  // idle line levels
  initial begin
    rxd = 1'b1;
    xck = 1'b1;
  end
endmodule

// File: test_usart_clock_and_baud_generation.sv
`timescale 1ns/1ps
module test_usart_clock_and_baud_generation;
  // ====================================
  // bench signals
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic rxd, txd, xck_i, xck_o, xck_oe, irq;
  int bad_count = 0;
  int check_count = 0;

  // 25 mhz clock
  always #20 hclk = ~hclk;

  // ====================================
  // design and far end
  ucg_top u_ucg_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd_i(rxd),
    .txd_o(txd), .xck_i(xck_i), .xck_o(xck_o), .xck_oe(xck_oe), .irq(irq)
  );
  ucg_remote u_ucg_remote (.clk(hclk), .txd(txd), .rxd(rxd), .xck(xck_i));

  // ====================================
  // verdict, used by the end and the watchdog
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // compare one value
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {27'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  // poll a status bit, bounded
  task automatic wait_stat(input int b);
    logic [31:0] v;
    for (int n = 0; n < 300; n++) begin
      rd(ucg_pkg::A_STAT, v);
      if (v[b] === 1'b1) return;
    end
    bad_count++;
    finish_test();
  endtask

  // two frames, second written once the buffer frees
  task automatic tx_pair(input logic [7:0] d0, input logic [7:0] d1, input int bitc);
    u_ucg_remote.got_q.delete();
    u_ucg_remote.start_t.delete();
    wr(ucg_pkg::A_DATA, {24'h0, d0});
    wait_stat(6);
    wr(ucg_pkg::A_DATA, {24'h0, d1});
    for (int n = 0; n < 4000 && u_ucg_remote.got_q.size() < 2; n++) begin
      @(posedge hclk);
    end
    if (u_ucg_remote.got_q.size() < 2) begin
      bad_count++;
      finish_test();
    end
    check("tx word 0", 32'(u_ucg_remote.got_q[0][7:0]), 32'(d0));
    check("tx word 1", 32'(u_ucg_remote.got_q[1][7:0]), 32'(d1));
    check("tx stop", 32'(u_ucg_remote.got_q[0][u_ucg_remote.rx_bits - 1]), 32'h1);
    // start to start in ns: whole frame, no idle gap between
    check("spacing", 32'(u_ucg_remote.start_t[1] - u_ucg_remote.start_t[0]),
          32'((u_ucg_remote.rx_bits + 1) * bitc * 40));
  endtask

  // ====================================
  // xck rise to rise, sampled mid cycle
  task automatic xck_period(output int p);
    int r[$];
    logic prev;
    prev = xck_o;
    for (int n = 0; n < 3000 && r.size() < 2; n++) begin
      @(negedge hclk);
      if (xck_o === 1'b1 && prev === 1'b0) r.push_back(n);
      prev = xck_o;
    end
    p = (r.size() < 2) ? -1 : r[1] - r[0];
  endtask

  // watchdog against hangs
  initial begin
    repeat (100000) @(posedge hclk);
    bad_count++;
    finish_test();
  end

  // ====================================
  // main sequence
  initial begin : main
    logic [31:0] v;
    int p;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    // reset levels and values
    check("txd idle", 32'(txd), 32'h1);
    check("xck_oe", 32'(xck_oe), 32'h0);
    check("hresp", 32'(hresp), 32'h0);
    check("hreadyout", 32'(hreadyout), 32'h1);
    rd(ucg_pkg::A_CTRL, v);
    check("ctrl", v, 32'h0C0);
    rd(ucg_pkg::A_STAT, v);
    check("stat", 32'(v[5:0]), 32'h0);
    rd(5'h18, v);
    check("unmapped", v, 32'h0);
    // divider 0x100: master xck toggles every 257 clocks
    wr(ucg_pkg::A_BHI, 32'h1);
    wr(ucg_pkg::A_BLO, 32'h0);
    rd(ucg_pkg::A_BHI, v);
    check("div high", v, 32'h1);
    wr(ucg_pkg::A_CTRL, 32'h0E4);
    @(negedge hclk);
    check("master oe", 32'(xck_oe), 32'h1);
    xck_period(p);
    check("xck period", 32'(p), 32'd514);
    wr(ucg_pkg::A_CTRL, 32'h0C4);
    @(negedge hclk);
    check("slave oe", 32'(xck_oe), 32'h0);
    // async normal, 2 clocks a pulse, 32 a bit; receive at the same time
    wr(ucg_pkg::A_BHI, 32'h0);
    wr(ucg_pkg::A_BLO, 32'h1);
    wr(ucg_pkg::A_CTRL, 32'h0C3);
    fork
      u_ucg_remote.send(11'h15A, 9);
    join_none
    tx_pair(8'h3C, 8'hC3, 32);
    wait_stat(ucg_pkg::S_RXC);
    rd(ucg_pkg::A_DATA, v);
    check("rx word", v, 32'h5A);
    // transmit complete interrupt, masked then cleared
    wait_stat(ucg_pkg::S_TXC);
    wr(ucg_pkg::A_MASK, 32'h1);
    @(negedge hclk);
    check("irq on", 32'(irq), 32'h1);
    wr(ucg_pkg::A_STAT, 32'h3F);
    @(negedge hclk);
    check("irq off", 32'(irq), 32'h0);
    // even parity both ways
    wr(ucg_pkg::A_CTRL, 32'h4C3);
    u_ucg_remote.rx_bits = 10;
    tx_pair(8'h01, 8'h03, 32);
    check("par 0", 32'(u_ucg_remote.got_q[0][8]), 32'h1);
    check("par 1", 32'(u_ucg_remote.got_q[1][8]), 32'h0);
    u_ucg_remote.send(11'h30F, 10);
    wait_stat(ucg_pkg::S_RXC);
    rd(ucg_pkg::A_STAT, v);
    check("pe", 32'(v[ucg_pkg::S_PE]), 32'h1);
    rd(ucg_pkg::A_DATA, v);
    // stop bit low gives a framing error
    wr(ucg_pkg::A_CTRL, 32'h0C3);
    u_ucg_remote.rx_bits = 9;
    wr(ucg_pkg::A_STAT, 32'h3F);
    u_ucg_remote.send(11'h055, 9);
    wait_stat(ucg_pkg::S_RXC);
    rd(ucg_pkg::A_STAT, v);
    check("fe", 32'(v[ucg_pkg::S_FE]), 32'h1);
    rd(ucg_pkg::A_DATA, v);
    // second word while first unread: overrun, first kept
    wr(ucg_pkg::A_STAT, 32'h3F);
    u_ucg_remote.send(11'h111, 9);
    wait_stat(ucg_pkg::S_RXC);
    u_ucg_remote.send(11'h122, 9);
    wait_stat(ucg_pkg::S_DOR);
    rd(ucg_pkg::A_DATA, v);
    check("overrun", v, 32'h11);
    // short low pulse must not start a frame
    wr(ucg_pkg::A_STAT, 32'h3F);
    u_ucg_remote.glitch();
    repeat (400) @(posedge hclk);
    rd(ucg_pkg::A_STAT, v);
    check("false start", 32'(v[ucg_pkg::S_RXC]), 32'h0);
    // double speed halves the bit time
    wr(ucg_pkg::A_CTRL, 32'h0CB);
    u_ucg_remote.bit_clks = 16;
    tx_pair(8'hA5, 8'h5A, 16);
    // odd parity and two stop bits, still double speed
    wr(ucg_pkg::A_CTRL, 32'hECB);
    u_ucg_remote.rx_bits = 11;
    tx_pair(8'h01, 8'h03, 16);
    check("odd par 0", 32'(u_ucg_remote.got_q[0][8]), 32'h0);
    check("odd par 1", 32'(u_ucg_remote.got_q[1][8]), 32'h1);
    check("stop one", 32'(u_ucg_remote.got_q[0][9]), 32'h1);
    // sync master transmit, data moves on falling xck, 4 clocks a bit
    wr(ucg_pkg::A_CTRL, 32'h0F6);
    u_ucg_remote.rx_bits = 9;
    u_ucg_remote.bit_clks = 4;
    tx_pair(8'h69, 8'h96, 4);
    // sync slave receive, polarity 1, interrupt on receive
    wr(ucg_pkg::A_CTRL, 32'h0D5);
    wr(ucg_pkg::A_STAT, 32'h3F);
    wr(ucg_pkg::A_MASK, 32'h4);
    u_ucg_remote.bit_clks = 8;
    u_ucg_remote.sync_mode = 1'b1;
    u_ucg_remote.send(11'h196, 9);
    wait_stat(ucg_pkg::S_RXC);
    @(negedge hclk);
    check("rx irq", 32'(irq), 32'h1);
    rd(ucg_pkg::A_DATA, v);
    check("sync rx", v, 32'h96);
    finish_test();
  end
endmodule
